/* dcf_consts.svh */
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ****************************************
// Sizes
// ****************************************
`define DCF_DATA_W 36
`define DCF_DEPTH_LOG2 16
`define DCF_OFS_W 17

// ****************************************
// Default offsets, indexed by {load, sel1, sel0}
// ****************************************
`define DCF_OFS_LLL 17'h0007F
`define DCF_OFS_LLH 17'h01FFF
`define DCF_OFS_LHL 17'h03FFF
`define DCF_OFS_LHH 17'h00FFF
`define DCF_OFS_HLL 17'h003FF
`define DCF_OFS_HLH 17'h001FF
`define DCF_OFS_HHL 17'h007FF
`define DCF_OFS_HHH 17'h000FF

// ****************************************
// Controller register offsets (byte addresses)
// ****************************************
`define DCF_REG_CTRL 8'h00
`define DCF_REG_WDATA_LO 8'h04
`define DCF_REG_WDATA_HI 8'h08
`define DCF_REG_PUSH 8'h0C
`define DCF_REG_POP 8'h10
`define DCF_REG_RDATA_LO 8'h14
`define DCF_REG_RDATA_HI 8'h18
`define DCF_REG_STATUS 8'h1C

// ****************************************
// Control register fields and reset value
// ****************************************
`define DCF_CTRL_RUN 0
`define DCF_CTRL_MODE 1
`define DCF_CTRL_LOAD 2
`define DCF_CTRL_SEL0 3
`define DCF_CTRL_SEL1 4
`define DCF_CTRL_W 5
`define DCF_CTRL_RESET 5'h00

// ****************************************
// Status register fields
// ****************************************
`define DCF_ST_EMPTY_N 0
`define DCF_ST_FULL_N 1
`define DCF_ST_AEMPTY_N 2
`define DCF_ST_AFULL_N 3
`define DCF_ST_HALF_N 4
`define DCF_ST_OREADY_N 5
`define DCF_ST_IREADY_N 6
`define DCF_ST_FALL_THROUGH_MODE 7
`define DCF_ST_DROP 8

`endif

/* dcf_device.sv */
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "dcf_consts.svh"

module dcf_device #(
  parameter int DATA_W = `DCF_DATA_W,
  parameter int AW = `DCF_DEPTH_LOG2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  dcf_fifo_if.dev link,
  output logic fall_through_mode_o
);

  localparam int PW = AW + 1;
  localparam int CW = AW + 2;
  localparam logic [CW-1:0] DEPTH_C = {2'b01, {AW{1'b0}}};
  localparam logic [CW-1:0] HALF_C = {3'b001, {(AW-1){1'b0}}};

  // ****************************************
  // Gray helpers
  // ****************************************
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--)
    begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic mrst;
  dcf_pkg::dcf_mode_t mode_reg;
  logic [`DCF_OFS_W-1:0] ofs_reg;
  logic [`DCF_OFS_W-1:0] ofs_default;
  logic fall_through_mode;
  logic [CW-1:0] add_c;
  logic [DATA_W-1:0] mem [0:(1<<AW)-1];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] wgray_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW-1:0] rgray_reg;
  logic [PW-1:0] wsync1_reg;
  logic [PW-1:0] wsync2_reg;
  logic [PW-1:0] rsync1_reg;
  logic [PW-1:0] rsync2_reg;
  logic ovsync1_reg;
  logic ovsync2_reg;
  logic ovalid_reg;
  logic ovalid_next;
  logic [DATA_W-1:0] dout_reg;
  logic [CW-1:0] mem_wcnt;
  logic [CW-1:0] mem_rcnt;
  logic [CW-1:0] wtot_next;
  logic [CW-1:0] rtot_next;
  logic wr_ok;
  logic rd_take;
  logic load_out;
  logic radv;
  logic empty_n_reg;
  logic full_n_reg;
  logic aempty_n_reg;
  logic afull_n_reg;
  logic half_n_reg;
  logic ir_n_reg;

  // Either reset clears pointers and flags; both are on clk_i
  assign mrst = !rst_n_i || !link.master_reset_n;

  // ****************************************
  // Straps caught while master reset is held
  // ****************************************
  // Default offset chosen from {load, sel1, sel0}
  always_comb
  begin
    case ({link.load_select_n, link.offset_default_select_1, link.offset_default_select_0})
      3'h0: ofs_default = `DCF_OFS_LLL;
      3'h1: ofs_default = `DCF_OFS_LLH;
      3'h2: ofs_default = `DCF_OFS_LHL;
      3'h3: ofs_default = `DCF_OFS_LHH;
      3'h4: ofs_default = `DCF_OFS_HLL;
      3'h5: ofs_default = `DCF_OFS_HLH;
      3'h6: ofs_default = `DCF_OFS_HHL;
      default: ofs_default = `DCF_OFS_HHH;
    endcase
  end

  // Mode and offsets latched from the pins, clocked
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mode_reg <= dcf_pkg::DCF_STANDARD;
      ofs_reg <= `DCF_OFS_LLL;
    end
    else if (!link.master_reset_n)
    begin
      mode_reg <= link.mode_select_serial_in ? dcf_pkg::DCF_FALL_THROUGH
                                              : dcf_pkg::DCF_STANDARD;
      ofs_reg <= ofs_default;
    end
  end

  assign fall_through_mode = (mode_reg == dcf_pkg::DCF_FALL_THROUGH);
  assign add_c = {{(CW-1){1'b0}}, fall_through_mode};
  assign fall_through_mode_o = fall_through_mode;

  // ****************************************
  // Write side
  // ****************************************
  // Words in memory as seen by the writer; memory full blocks writes
  assign mem_wcnt = {1'b0, PW'(wptr_reg - gray2bin(rsync2_reg))};
  assign wr_ok = !link.wr_en_n && (mem_wcnt != DEPTH_C);

  // Storage array
  always_ff @(posedge clk_i)
  begin
    if (wr_ok)
    begin
      mem[wptr_reg[AW-1:0]] <= link.data_in;
    end
  end

  // Write pointer in binary and gray, updated together
  always_ff @(posedge clk_i)
  begin
    if (mrst)
    begin
      wptr_reg <= '0;
      wgray_reg <= '0;
    end
    else
    begin
      wptr_reg <= wptr_reg + PW'(wr_ok);
      wgray_reg <= bin2gray(wptr_reg + PW'(wr_ok));
    end
  end

  // Read pointer and output-valid into the write side, two stages
  always_ff @(posedge clk_i)
  begin
    if (mrst)
    begin
      rsync1_reg <= '0;
      rsync2_reg <= '0;
      ovsync1_reg <= 1'b0;
      ovsync2_reg <= 1'b0;
    end
    else
    begin
      rsync1_reg <= rgray_reg;
      rsync2_reg <= rsync1_reg;
      ovsync1_reg <= ovalid_reg;
      ovsync2_reg <= ovsync1_reg;
    end
  end

  // Held words after this edge, output register counted in fall-through
  assign wtot_next = mem_wcnt + CW'(wr_ok) + (fall_through_mode ? CW'(ovsync2_reg) : '0);

  // Write-side flags
  always_ff @(posedge clk_i)
  begin
    if (mrst)
    begin
      full_n_reg <= 1'b1;
      ir_n_reg <= 1'b0;
      half_n_reg <= 1'b1;
      afull_n_reg <= 1'b1;
    end
    else
    begin
      full_n_reg <= fall_through_mode || (wtot_next != DEPTH_C);
      ir_n_reg <= fall_through_mode && (wtot_next == DEPTH_C + 1'b1);
      half_n_reg <= !(wtot_next >= HALF_C + 1'b1 + add_c);
      afull_n_reg <= !(wtot_next >= DEPTH_C - CW'(ofs_reg) + add_c);
    end
  end

  // ****************************************
  // Read side
  // ****************************************
  // Write pointer into the read side, two stages
  always_ff @(posedge clk_i)
  begin
    if (mrst)
    begin
      wsync1_reg <= '0;
      wsync2_reg <= '0;
    end
    else
    begin
      wsync1_reg <= wgray_reg;
      wsync2_reg <= wsync1_reg;
    end
  end

  assign mem_rcnt = {1'b0, PW'(gray2bin(wsync2_reg) - rptr_reg)}; // Distance modulo pointer width

  // Standard reads need a request; reads while empty are ignored
  assign rd_take = !fall_through_mode && !link.rd_en_n && (mem_rcnt != '0);
  // Fall-through refills the output register unrequested when it is free
  assign load_out = fall_through_mode && (mem_rcnt != '0) && (!ovalid_reg || !link.rd_en_n);
  assign radv = rd_take || load_out;

  // Output register state; a read with nothing behind it empties it
  always_comb
  begin
    ovalid_next = ovalid_reg;
    if (load_out)
    begin
      ovalid_next = 1'b1;
    end
    else if (fall_through_mode && !link.rd_en_n)
    begin
      ovalid_next = 1'b0;
    end
  end

  // Read pointer, output register and output data
  always_ff @(posedge clk_i)
  begin
    if (mrst)
    begin
      rptr_reg <= '0;
      rgray_reg <= '0;
      ovalid_reg <= 1'b0;
      dout_reg <= '0;
    end
    else
    begin
      rptr_reg <= rptr_reg + PW'(radv);
      rgray_reg <= bin2gray(rptr_reg + PW'(radv));
      ovalid_reg <= ovalid_next;
      if (radv)
      begin
        dout_reg <= mem[rptr_reg[AW-1:0]];
      end
    end
  end

  // Held words after this edge, as seen by the reader
  assign rtot_next = mem_rcnt - CW'(radv) + (fall_through_mode ? CW'(ovalid_next) : '0);

  // Read-side flags
  always_ff @(posedge clk_i)
  begin
    if (mrst)
    begin
      empty_n_reg <= 1'b0;
      aempty_n_reg <= 1'b0;
    end
    else
    begin
      empty_n_reg <= fall_through_mode || (rtot_next != '0);
      aempty_n_reg <= (rtot_next > CW'(ofs_reg) + add_c);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.data_out_bus = dout_reg;
  assign link.empty_flag_n = empty_n_reg;
  assign link.full_flag_n = full_n_reg;
  assign link.almost_empty_flag_n = aempty_n_reg;
  assign link.almost_full_flag_n = afull_n_reg;
  assign link.half_full_flag_n = half_n_reg;
  assign link.output_ready_flag_n = !(fall_through_mode && ovalid_reg);
  assign link.input_ready_flag_n = ir_n_reg;

endmodule

/* dcf_fifo_if.sv */
`timescale 1ns/1ps
`include "dcf_consts.svh"

interface dcf_fifo_if #(parameter int DATA_W = `DCF_DATA_W);
  logic master_reset_n;
  logic mode_select_serial_in;
  logic load_select_n;
  logic offset_default_select_0;
  logic offset_default_select_1;
  logic wr_en_n;
  logic [DATA_W-1:0] data_in;
  logic rd_en_n;
  logic [DATA_W-1:0] data_out_bus;
  logic empty_flag_n;
  logic full_flag_n;
  logic almost_empty_flag_n;
  logic almost_full_flag_n;
  logic half_full_flag_n;
  logic output_ready_flag_n;
  logic input_ready_flag_n;

  modport dev (
    input master_reset_n, mode_select_serial_in, load_select_n,
    input offset_default_select_0, offset_default_select_1,
    input wr_en_n, data_in, rd_en_n,
    output data_out_bus, empty_flag_n, full_flag_n, almost_empty_flag_n,
    output almost_full_flag_n, half_full_flag_n, output_ready_flag_n, input_ready_flag_n
  );

  modport host (
    output master_reset_n, mode_select_serial_in, load_select_n,
    output offset_default_select_0, offset_default_select_1,
    output wr_en_n, data_in, rd_en_n,
    input data_out_bus, empty_flag_n, full_flag_n, almost_empty_flag_n,
    input almost_full_flag_n, half_full_flag_n, output_ready_flag_n, input_ready_flag_n
  );
endinterface

/* dcf_fifo_sva.sv */
`timescale 1ns/1ps

// ****************************************
// Flag checker on the FIFO link
// ****************************************
module dcf_fifo_sva (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic master_reset_n,
  input wire logic mode_select_serial_in,
  input wire logic wr_en_n,
  input wire logic rd_en_n,
  input wire logic empty_flag_n,
  input wire logic full_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic half_full_flag_n,
  input wire logic output_ready_flag_n,
  input wire logic input_ready_flag_n
);
  logic fall_through_mode_q;
  logic [1:0] live_cnt;
  logic live;

  // Mode caught from the strap while the device is held
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      fall_through_mode_q <= 1'b0;
    else if (!master_reset_n)
      fall_through_mode_q <= mode_select_serial_in;
  end

  // Flags get a few edges to leave their reset values
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !master_reset_n)
      live_cnt <= 2'h0;
    else if (live_cnt != 2'h3)
      live_cnt <= live_cnt + 2'h1;
  end
  assign live = (live_cnt == 2'h3);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_std_spare_flags : assert property (
    live && !fall_through_mode_q |-> output_ready_flag_n && !input_ready_flag_n)
    else $error("standard mode shows fall-through flags");
  a_fall_through_mode_spare_flags : assert property (
    live && fall_through_mode_q |-> empty_flag_n && full_flag_n)
    else $error("fall-through mode shows standard flags");
  a_mreset_empty : assert property (
    !master_reset_n |=> !empty_flag_n && !almost_empty_flag_n && full_flag_n
      && almost_full_flag_n && half_full_flag_n)
    else $error("flags not empty after master reset");
  a_first_word_fall : assert property (
    live && fall_through_mode_q && output_ready_flag_n && !wr_en_n && $past(wr_en_n)
      && $past(wr_en_n, 2) && $past(wr_en_n, 3)
      |=> output_ready_flag_n [*2] ##[1:2] !output_ready_flag_n)
    else $error("first word latency wrong");
  a_empty_two_stage : assert property (
    live && !fall_through_mode_q && !empty_flag_n && !wr_en_n && $past(wr_en_n)
      && $past(wr_en_n, 2) && $past(wr_en_n, 3) && $past(wr_en_n, 4)
      |=> !empty_flag_n [*2] ##[1:3] empty_flag_n)
    else $error("empty flag timing wrong");
  a_full_release : assert property (
    live && !fall_through_mode_q && !full_flag_n && !rd_en_n |-> ##[1:5] full_flag_n)
    else $error("full flag not released by read");
  a_ir_release : assert property (
    live && fall_through_mode_q && input_ready_flag_n && !rd_en_n |-> ##[1:5] !input_ready_flag_n)
    else $error("input ready not released by read");
  a_std_full_order : assert property (
    live && !fall_through_mode_q && !full_flag_n
      |-> !almost_full_flag_n && !half_full_flag_n && almost_empty_flag_n)
    else $error("flags inconsistent at full");
  a_fall_through_mode_full_order : assert property (
    live && fall_through_mode_q && input_ready_flag_n
      |-> !almost_full_flag_n && !half_full_flag_n && almost_empty_flag_n)
    else $error("flags inconsistent at input ready");
  a_std_empty_order : assert property (
    live && !fall_through_mode_q && !empty_flag_n |-> !almost_empty_flag_n && half_full_flag_n)
    else $error("flags inconsistent at empty");
endmodule

/* dcf_host.sv */
`timescale 1ns/1ps
`include "dcf_consts.svh"

module dcf_host #(
  parameter int DATA_W = `DCF_DATA_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  dcf_fifo_if.host link
);

  logic ack_reg;
  logic [31:0] dat_reg;
  logic [`DCF_CTRL_W-1:0] ctrl_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic wr_en_n_reg;
  logic rd_en_n_reg;
  logic drop_reg;
  logic wr_strobe;
  logic fall_through_mode;
  logic space;
  logic avail;
  logic [31:0] rd_mux;
  logic [31:0] status;

  // ****************************************
  // Bus slave
  // ****************************************
  // Write takes effect at the edge where ack is seen high
  assign wr_strobe = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign fall_through_mode = !link.output_ready_flag_n || ctrl_reg[`DCF_CTRL_MODE];
  assign space = fall_through_mode ? !link.input_ready_flag_n : link.full_flag_n;
  assign avail = fall_through_mode ? !link.output_ready_flag_n : link.empty_flag_n;

  // One-cycle ack, dropped in the following cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ack_reg <= 1'b0;
    end
    else
    begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  // Status word from the device flags, the control register mode bit and the sticky drop bit
  always_comb
  begin
    status = 32'h00000000;
    status[`DCF_ST_EMPTY_N] = link.empty_flag_n;
    status[`DCF_ST_FULL_N] = link.full_flag_n;
    status[`DCF_ST_AEMPTY_N] = link.almost_empty_flag_n;
    status[`DCF_ST_AFULL_N] = link.almost_full_flag_n;
    status[`DCF_ST_HALF_N] = link.half_full_flag_n;
    status[`DCF_ST_OREADY_N] = link.output_ready_flag_n;
    status[`DCF_ST_IREADY_N] = link.input_ready_flag_n;
    status[`DCF_ST_FALL_THROUGH_MODE] = ctrl_reg[`DCF_CTRL_MODE];
    status[`DCF_ST_DROP] = drop_reg;
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    case (wb_adr_i)
      `DCF_REG_CTRL: rd_mux = {{(32-`DCF_CTRL_W){1'b0}}, ctrl_reg};
      `DCF_REG_WDATA_LO: rd_mux = wdata_reg[31:0];
      `DCF_REG_WDATA_HI: rd_mux = 32'(wdata_reg[DATA_W-1:32]);
      `DCF_REG_RDATA_LO: rd_mux = link.data_out_bus[31:0];
      `DCF_REG_RDATA_HI: rd_mux = 32'(link.data_out_bus[DATA_W-1:32]);
      `DCF_REG_STATUS: rd_mux = status;
      default: rd_mux = 32'h00000000;
    endcase
  end

  // Read data registered on the edge that raises ack
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      dat_reg <= 32'h00000000;
    end
    else if (wb_cyc_i && wb_stb_i && !ack_reg)
    begin
      dat_reg <= rd_mux;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ****************************************
  // Control and write data registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ctrl_reg <= `DCF_CTRL_RESET;
      wdata_reg <= '0;
    end
    else if (wr_strobe)
    begin
      if (wb_adr_i == `DCF_REG_CTRL && wb_sel_i[0])
      begin
        ctrl_reg <= wb_dat_i[`DCF_CTRL_W-1:0];
      end
      if (wb_adr_i == `DCF_REG_WDATA_LO)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (wb_sel_i[b])
          begin
            wdata_reg[8*b +: 8] <= wb_dat_i[8*b +: 8];
          end
        end
      end
      if (wb_adr_i == `DCF_REG_WDATA_HI && wb_sel_i[0])
      begin
        wdata_reg[DATA_W-1:32] <= wb_dat_i[DATA_W-33:0];
      end
    end
  end

  // ****************************************
  // Push and pop strobes to the device
  // ****************************************
  // Push holds write enable low one cycle, only with space; pop likewise
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_en_n_reg <= 1'b1;
      rd_en_n_reg <= 1'b1;
    end
    else
    begin
      wr_en_n_reg <= !(wr_strobe && wb_adr_i == `DCF_REG_PUSH && space);
      rd_en_n_reg <= !(wr_strobe && wb_adr_i == `DCF_REG_POP && avail);
    end
  end

  // Sticky: a push or pop refused for lack of space or data; set wins
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      drop_reg <= 1'b0;
    end
    else if (wr_strobe && ((wb_adr_i == `DCF_REG_PUSH && !space)
                           || (wb_adr_i == `DCF_REG_POP && !avail)))
    begin
      drop_reg <= 1'b1;
    end
    else if (wr_strobe && wb_adr_i == `DCF_REG_STATUS && wb_dat_i[`DCF_ST_DROP])
    begin
      drop_reg <= 1'b0;
    end
  end

  // ****************************************
  // Straps and master reset
  // ****************************************
  // Straps hold steady while master reset is asserted
  assign link.master_reset_n = ctrl_reg[`DCF_CTRL_RUN];
  assign link.mode_select_serial_in = ctrl_reg[`DCF_CTRL_MODE];
  assign link.load_select_n = ctrl_reg[`DCF_CTRL_LOAD];
  assign link.offset_default_select_0 = ctrl_reg[`DCF_CTRL_SEL0];
  assign link.offset_default_select_1 = ctrl_reg[`DCF_CTRL_SEL1];
  assign link.wr_en_n = wr_en_n_reg;
  assign link.rd_en_n = rd_en_n_reg;
  assign link.data_in = wdata_reg;

endmodule

/* dcf_pkg.sv */
package dcf_pkg;

  // Timing mode caught from the strap at master reset
  typedef enum logic {DCF_STANDARD, DCF_FALL_THROUGH} dcf_mode_t;

endpackage

/* tb_top.sv */
`timescale 1ns/1ps
`include "dcf_consts.svh"

module tb_top;
  localparam int AW = 9;
  localparam int D = 1 << AW;
  logic clk;
  logic rst_n;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  logic ft_mode;
  int n_mismatch;
  int check_count;

  // ****************************************
  // Both ends joined by the link
  // ****************************************
  dcf_fifo_if bus ();
  dcf_device #(.AW(AW)) dcf_device_i (.clk_i(clk), .rst_n_i(rst_n), .link(bus),
    .fall_through_mode_o(ft_mode));
  dcf_host dcf_host_i (.clk_i(clk), .rst_n_i(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .link(bus));
  dcf_fifo_sva dcf_fifo_sva_i (.clk_i(clk), .rst_n_i(rst_n),
    .master_reset_n(bus.master_reset_n), .mode_select_serial_in(bus.mode_select_serial_in),
    .wr_en_n(bus.wr_en_n), .rd_en_n(bus.rd_en_n), .empty_flag_n(bus.empty_flag_n),
    .full_flag_n(bus.full_flag_n), .almost_empty_flag_n(bus.almost_empty_flag_n),
    .almost_full_flag_n(bus.almost_full_flag_n), .half_full_flag_n(bus.half_full_flag_n),
    .output_ready_flag_n(bus.output_ready_flag_n),
    .input_ready_flag_n(bus.input_ready_flag_n));

  // Clock of 20 ns period
  always #10 clk = ~clk;

  // ****************************************
  // Reporting and bus cycles
  // ****************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Classic single cycle, held until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wdat,
                         output logic [31:0] rdat);
    int k;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= 4'hF;
    wb_dat_w <= wdat;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wb_ack !== 1'b1 && k < 20);
    if (wb_ack !== 1'b1)
    begin
      n_mismatch++;
      print_verdict();
    end
    rdat = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, dat, unused);
  endtask

  task automatic wb_rd(input logic [7:0] adr, output logic [31:0] dat);
    wb_xfer(1'b0, adr, 32'h0000_0000, dat);
  endtask

  // Status byte expected for t words held; offsets n = m
  function automatic logic [7:0] exp_status(input int t, input logic ft, input int n);
    return {ft, ft ? t == D + 1 : 1'b0, ft ? t == 0 : 1'b1, !(t >= D / 2 + 1 + int'(ft)),
      !(t >= D - n + int'(ft)), t > n + int'(ft), ft ? 1'b1 : t != D, ft ? 1'b1 : t != 0};
  endfunction

  // Flags cross two or three stages, so let them settle first
  task automatic st_check(input int t, input logic ft, input int n);
    logic [31:0] r;
    repeat (8) @(posedge clk);
    wb_rd(`DCF_REG_STATUS, r);
    check({28'h0, r[7:0]}, {28'h0, exp_status(t, ft, n)});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_regs();
    logic [31:0] r;
    wb_rd(`DCF_REG_CTRL, r);
    check(36'(r), 36'(`DCF_CTRL_RESET));
    wb_rd(`DCF_REG_STATUS, r);
    check(36'(r), 36'h0_0000_003A);
    wb_wr(8'h20, 32'hFFFF_FFFF);
    wb_rd(8'h20, r);
    check(36'(r), 36'h0);
    check(36'(ft_mode), 36'h0);
  endtask

  // Master reset with straps, then release
  task automatic t_start(input logic ft, input logic [4:0] c, input int n);
    logic [31:0] r;
    wb_wr(`DCF_REG_CTRL, {27'h0, c});
    wb_wr(`DCF_REG_CTRL, {27'h0, c | 5'h01});
    wb_rd(`DCF_REG_CTRL, r);
    check(36'(r), 36'(c | 5'h01));
    check(36'(ft_mode), 36'(ft));
    st_check(0, ft, n);
  endtask

  task automatic t_fill(input logic ft, input int n);
    logic [31:0] r;
    wb_wr(`DCF_REG_WDATA_HI, 32'h0000_000A);
    for (int t = 1; t <= D + int'(ft); t++)
    begin
      wb_wr(`DCF_REG_WDATA_LO, 32'h5A00_0000 + 32'(t));
      wb_wr(`DCF_REG_PUSH, 32'h0000_0000);
      st_check(t, ft, n);
    end
    // One push beyond capacity is dropped and flagged
    wb_wr(`DCF_REG_PUSH, 32'h0000_0000);
    st_check(D + int'(ft), ft, n);
    wb_rd(`DCF_REG_STATUS, r);
    check(36'(r[8]), 36'h1);
    wb_wr(`DCF_REG_STATUS, 32'h0000_0100);
    wb_rd(`DCF_REG_STATUS, r);
    check(36'(r[8]), 36'h0);
  endtask

  task automatic t_drain(input logic ft, input int n);
    logic [31:0] lo;
    logic [31:0] hi;
    int cap;
    cap = D + int'(ft);
    for (int t = cap; t >= 1; t--)
    begin
      if (!ft)
        wb_wr(`DCF_REG_POP, 32'h0000_0000);
      wb_rd(`DCF_REG_RDATA_LO, lo);
      wb_rd(`DCF_REG_RDATA_HI, hi);
      if (ft)
        wb_wr(`DCF_REG_POP, 32'h0000_0000);
      check({hi[3:0], lo}, {4'hA, 32'h5A00_0000 + 32'(cap - t + 1)});
      st_check(t - 1, ft, n);
    end
    // A pop from an empty FIFO is dropped
    wb_wr(`DCF_REG_POP, 32'h0000_0000);
    st_check(0, ft, n);
    wb_rd(`DCF_REG_STATUS, lo);
    check(36'(lo[8]), 36'h1);
    wb_wr(`DCF_REG_STATUS, 32'h0000_0100);
  endtask

  // Offset of 511 brings almost-full down at a single stored word
  task automatic t_offset();
    t_start(1'b0, 5'h0C, 511);
    wb_wr(`DCF_REG_PUSH, 32'h0000_0000);
    st_check(1, 1'b0, 511);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_dat_w = 32'h0000_0000;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_regs();
    t_start(1'b0, 5'h00, 127);
    t_fill(1'b0, 127);
    t_drain(1'b0, 127);
    // A second round carries both pointers through their wrap
    t_fill(1'b0, 127);
    t_drain(1'b0, 127);
    t_offset();
    t_start(1'b1, 5'h1E, 255);
    t_fill(1'b1, 255);
    t_drain(1'b1, 255);
    print_verdict();
  end
endmodule
